// File: rtl/block_irq_enable.sv
// Purpose: Block-level interrupt enable register and interrupt merge for one framer channel
// Assumes: AXI4-Lite slave on aclk; event inputs are one-cycle pulses synchronous to aclk
// Notes: Pending lines for loopback and data-link blocks are held here until their status read
//
// Summary of operation
// - Bit 6 read/write, reset zero, enables loopback-code block interrupts.
// - Loopback block enable zero blocks every loopback-code interrupt; here a status bit 6 latched earlier still drives irq while mask bit 6 is set.
// - Loopback block enabled: event forwarded only when its source enable is set.
// - Bit 5 read/write, reset zero, enables the recovered-clock-loss interrupt.
// - Bit 4 read/write, reset zero, enables the one-second interrupt.
// - Bit 3 read/write, reset zero, enables data-link block interrupts.
// - Data-link block enable zero blocks every data-link interrupt; here a status bit 3 latched earlier still drives irq while mask bit 3 is set.
// - Data-link block enabled: event passes only when its source enable is set.
// - Loopback block pending clears after host reads loopback source status.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "blk_irq_defines.svh"

module block_irq_enable #(
   parameter int LBC_SRC_W = `LBC_SRC_W,
   parameter int DL_SRC_W = `DL_SRC_W
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [`ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [`ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Source events (one-cycle pulses)
   input wire logic [LBC_SRC_W-1:0] loopback_code_event,
   input wire logic recovered_clock_loss_event,
   input wire logic one_second_event,
   input wire logic [DL_SRC_W-1:0] data_link_event,
   // Status reads of the source blocks (one-cycle pulses)
   input wire logic loopback_status_read,
   input wire logic data_link_status_read,
   // Interrupt
   output logic irq
);

   logic [7:0] block_irq_enable_reg;
   logic [7:0] src_en;
   logic [7:0] status;
   logic [7:0] mask;
   logic loopback_code_block_pending;
   logic data_link_block_pending;
   logic [`ADDR_W-1:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   blk_irq_pkg::wr_state_t wr_state;
   logic wr_fire;
   logic rd_fire;
   logic status_rd;
   logic lbc_hit;
   logic dl_hit;
   logic [7:0] ev_vec;
   logic next_irq;

   function automatic logic reg_hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
      reg_hit = (a[`ADDR_W-1:2] == off[`ADDR_W-1:2]);
   endfunction : reg_hit

   // Source enables: loopback sources use the low bits; data-link sources share bits 7:4 and 1:0
   logic [LBC_SRC_W-1:0] lbc_src_en;
   logic [DL_SRC_W-1:0] dl_src_en;
   assign lbc_src_en = src_en[LBC_SRC_W-1:0];
   assign dl_src_en = {src_en[7:4], src_en[1:0]};

   // Gated block contributions
   assign lbc_hit = block_irq_enable_reg[`BIT_LBC] && |(loopback_code_event & lbc_src_en);
   assign dl_hit = block_irq_enable_reg[`BIT_DL] && |(data_link_event & dl_src_en);

   assign wr_fire = aw_held && w_held && (wr_state == blk_irq_pkg::wr_idle);
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign status_rd = rd_fire && reg_hit(s_axi_araddr, `OFF_STATUS);

   // Write address and data captured in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
         s_axi_awready <= 1'b0;
      end else if (!aw_held && s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && (wr_state == blk_irq_pkg::wr_idle);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
         w_held <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (!w_held && s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held && (wr_state == blk_irq_pkg::wr_idle);
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= blk_irq_pkg::wr_idle;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         case (wr_state)
            blk_irq_pkg::wr_idle: begin
               if (wr_fire) begin
                  wr_state <= blk_irq_pkg::wr_resp;
                  s_axi_bvalid <= 1'b1;
                  if (reg_hit(aw_addr, `OFF_ENABLE) || reg_hit(aw_addr, `OFF_SRC_EN) ||
                      reg_hit(aw_addr, `OFF_MASK) || reg_hit(aw_addr, `OFF_STATUS) ||
                      reg_hit(aw_addr, `OFF_PENDING)) begin
                     s_axi_bresp <= `RESP_OKAY;
                  end else begin
                     s_axi_bresp <= `RESP_SLVERR;
                  end
               end
            end
            blk_irq_pkg::wr_resp: begin
               if (s_axi_bready) begin
                  wr_state <= blk_irq_pkg::wr_idle;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_state <= blk_irq_pkg::wr_idle;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // Block enable register; bit 7 and low bits are not writable here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         block_irq_enable_reg <= `ENABLE_RST;
      end else if (wr_fire && reg_hit(aw_addr, `OFF_ENABLE) && w_strb[0]) begin
         block_irq_enable_reg <= w_data[7:0] & `ENABLE_WMASK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_en <= `SRC_EN_RST;
      end else if (wr_fire && reg_hit(aw_addr, `OFF_SRC_EN) && w_strb[0]) begin
         src_en <= w_data[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask <= `MASK_RST;
      end else if (wr_fire && reg_hit(aw_addr, `OFF_MASK) && w_strb[0]) begin
         mask <= w_data[7:0] & `ENABLE_WMASK;
      end
   end

   // Block pending lines: set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loopback_code_block_pending <= 1'b0;
      end else if (lbc_hit) begin
         loopback_code_block_pending <= 1'b1;
      end else if (loopback_status_read) begin
         loopback_code_block_pending <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_link_block_pending <= 1'b0;
      end else if (dl_hit) begin
         data_link_block_pending <= 1'b1;
      end else if (data_link_status_read) begin
         data_link_block_pending <= 1'b0;
      end
   end

   // Sticky event status, cleared by a read; a new event in the read cycle survives
   always_comb begin
      ev_vec = 8'h00;
      ev_vec[`BIT_LBC] = lbc_hit;
      ev_vec[`BIT_RCL] = recovered_clock_loss_event && block_irq_enable_reg[`BIT_RCL];
      ev_vec[`BIT_ONESEC] = one_second_event && block_irq_enable_reg[`BIT_ONESEC];
      ev_vec[`BIT_DL] = dl_hit;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= 8'h00;
      end else if (status_rd) begin
         status <= ev_vec;
      end else begin
         status <= status | ev_vec;
      end
   end

   // Interrupt output: pending blocks plus unmasked sticky bits
   always_comb begin
      next_irq = (loopback_code_block_pending && block_irq_enable_reg[`BIT_LBC]) ||
                 (data_link_block_pending && block_irq_enable_reg[`BIT_DL]) ||
                 (|(status & mask));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   // Read channel: one read at a time, answer the cycle after acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         if (reg_hit(s_axi_araddr, `OFF_ENABLE)) begin
            s_axi_rdata <= {24'h000000, 1'b0, block_irq_enable_reg[6:0]};
         end else if (reg_hit(s_axi_araddr, `OFF_SRC_EN)) begin
            s_axi_rdata <= {24'h000000, src_en};
         end else if (reg_hit(s_axi_araddr, `OFF_STATUS)) begin
            s_axi_rdata <= {24'h000000, status};
         end else if (reg_hit(s_axi_araddr, `OFF_MASK)) begin
            s_axi_rdata <= {24'h000000, mask};
         end else if (reg_hit(s_axi_araddr, `OFF_PENDING)) begin
            s_axi_rdata <= {24'h000000, 1'b0, loopback_code_block_pending, 2'h0, data_link_block_pending, 3'h0};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // Checks
   property p_lbc_block_off;
      @(posedge aclk) disable iff (!aresetn)
         !block_irq_enable_reg[`BIT_LBC] && !loopback_code_block_pending |=> !loopback_code_block_pending;
   endproperty
   a_lbc_block_off: assert property (p_lbc_block_off) else $error("loopback pending set while disabled");

   property p_lbc_pass;
      @(posedge aclk) disable iff (!aresetn)
         (block_irq_enable_reg[`BIT_LBC] && |(loopback_code_event & lbc_src_en)) |=> loopback_code_block_pending;
   endproperty
   a_lbc_pass: assert property (p_lbc_pass) else $error("enabled loopback event not pending");

   property p_dl_block_off;
      @(posedge aclk) disable iff (!aresetn)
         !block_irq_enable_reg[`BIT_DL] && !data_link_block_pending |=> !data_link_block_pending;
   endproperty
   a_dl_block_off: assert property (p_dl_block_off) else $error("data-link pending set while disabled");

   property p_dl_pass;
      @(posedge aclk) disable iff (!aresetn)
         (block_irq_enable_reg[`BIT_DL] && |(data_link_event & dl_src_en)) |=> data_link_block_pending;
   endproperty
   a_dl_pass: assert property (p_dl_pass) else $error("enabled data-link event not pending");

   property p_lbc_clear;
      @(posedge aclk) disable iff (!aresetn)
         loopback_status_read && !lbc_hit |=> !loopback_code_block_pending;
   endproperty
   a_lbc_clear: assert property (p_lbc_clear) else $error("loopback pending not cleared by read");

   property p_irq_follow;
      @(posedge aclk) disable iff (!aresetn)
         ##1 irq == $past(next_irq);
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("irq does not follow pending and enables");

   property p_bit7_zero;
      @(posedge aclk) disable iff (!aresetn)
         rd_fire && reg_hit(s_axi_araddr, `OFF_ENABLE)
            |=> !s_axi_rdata[`BIT_RSVD] && !block_irq_enable_reg[`BIT_RSVD];
   endproperty
   a_bit7_zero: assert property (p_bit7_zero) else $error("reserved enable bit set");

   property p_onesec_gate;
      @(posedge aclk) disable iff (!aresetn)
         one_second_event && !block_irq_enable_reg[`BIT_ONESEC] && !status_rd && !status[`BIT_ONESEC]
            |=> !status[`BIT_ONESEC];
   endproperty
   a_onesec_gate: assert property (p_onesec_gate) else $error("one-second status set while disabled");

   property p_rcl_gate;
      @(posedge aclk) disable iff (!aresetn)
         recovered_clock_loss_event && block_irq_enable_reg[`BIT_RCL] |=> status[`BIT_RCL];
   endproperty
   a_rcl_gate: assert property (p_rcl_gate) else $error("clock-loss event not recorded");

   property p_enable_write;
      @(posedge aclk) disable iff (!aresetn)
         wr_fire && reg_hit(aw_addr, `OFF_ENABLE) && w_strb[0]
            |=> block_irq_enable_reg == ($past(w_data[7:0]) & `ENABLE_WMASK);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable register write lost");

   c_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire);
   c_read: cover property (@(posedge aclk) disable iff (!aresetn) rd_fire);
   c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
   c_lbc_clear: cover property (@(posedge aclk) disable iff (!aresetn) $fell(loopback_code_block_pending));

endmodule : block_irq_enable

// File: rtl/blk_irq_defines.svh
// Purpose: Offsets, bit positions, reset values and widths for the block interrupt enable logic
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: Offsets are byte addresses
`ifndef BLK_IRQ_DEFINES_SVH
`define BLK_IRQ_DEFINES_SVH

`define ADDR_W 8
`define OFF_ENABLE 8'h00
`define OFF_SRC_EN 8'h04
`define OFF_STATUS 8'h08
`define OFF_MASK 8'h0C
`define OFF_PENDING 8'h10

`define BIT_RSVD 7
`define BIT_LBC 6
`define BIT_RCL 5
`define BIT_ONESEC 4
`define BIT_DL 3

`define ENABLE_RST 8'h00
`define ENABLE_WMASK 8'h78
`define SRC_EN_RST 8'h00
`define MASK_RST 8'h00

`define LBC_SRC_W 4
`define DL_SRC_W 6

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: rtl/blk_irq_pkg.sv
// Purpose: Types for the block interrupt enable logic
// Assumes: Constants live in blk_irq_defines.svh
// Notes: None
package blk_irq_pkg;
   typedef enum logic [1:0] {
      ev_lbc,
      ev_rcl,
      ev_onesec,
      ev_dl
   } irq_event_t;
   typedef enum logic {
      wr_idle,
      wr_resp
   } wr_state_t;
endpackage : blk_irq_pkg

// File: verification/tb_block_irq_enable.sv
// Purpose: Self-checking bench for the block interrupt enable logic over AXI4-Lite
// Assumes: Events and status-read strobes are one-cycle pulses on aclk
// Notes: Sources of a block are enabled all together, so the source-enable layout does not matter
`timescale 1ns/100ps
`include "blk_irq_defines.svh"

module tb_block_irq_enable;
   logic aclk, aresetn;
   logic [`ADDR_W-1:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [31:0] wdata, rdata, eb;
   logic [3:0] wstrb, lbc_ev;
   logic [1:0] bresp, rresp;
   logic [5:0] dl_ev;
   logic rcl_ev, sec_ev, lbc_rd, dl_rd;
   int n_fail = 0;
   int tests_run = 0;

   block_irq_enable dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .loopback_code_event(lbc_ev), .recovered_clock_loss_event(rcl_ev),
      .one_second_event(sec_ev), .data_link_event(dl_ev),
      .loopback_status_read(lbc_rd), .data_link_status_read(dl_rd), .irq(irq)
   );

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
      logic aw_d, w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Only the watchdog ends a wait that never completes
      while (!(aw_d && w_d)) begin
         @(posedge aclk);
         aw_d |= awready;
         w_d |= wready;
         if (aw_d) awvalid <= 1'b0;
         if (w_d) wvalid <= 1'b0;
      end
      // Response may only be sampled after both channels were taken
      do begin
         @(posedge aclk);
      end while (!bvalid);
      check({30'h0, bresp}, {30'h0, exp});
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_r, input bit cmp = 1'b1);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (!arready);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
      end while (!rvalid);
      if (cmp) check(rdata, exp);
      check({30'h0, rresp}, {30'h0, exp_r});
      rready <= 1'b0;
   endtask : rd

   // Kinds 0..3 are source events, 4 and 5 the loopback and data-link status reads
   task automatic fire(input int k);
      @(posedge aclk);
      lbc_ev <= (k == 0) ? 4'hF : 4'h0;
      rcl_ev <= (k == 1);
      sec_ev <= (k == 2);
      dl_ev <= (k == 3) ? 6'h3F : 6'h00;
      lbc_rd <= (k == 4);
      dl_rd <= (k == 5);
      @(posedge aclk);
      {lbc_ev, rcl_ev, sec_ev, dl_ev, lbc_rd, dl_rd} <= '0;
      repeat (3) @(posedge aclk);
   endtask : fire

   task automatic chk_irq(input logic e);
      // irq is registered one edge behind the state written by the last access
      @(posedge aclk);
      check({31'h0, irq}, {31'h0, e});
   endtask : chk_irq

   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      report_and_stop();
   end

   initial begin
      {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
      {lbc_ev, rcl_ev, sec_ev, dl_ev, lbc_rd, dl_rd} = '0;
      wstrb = 4'hF;
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`OFF_ENABLE, 32'h0, `RESP_OKAY);
      rd(`OFF_SRC_EN, 32'h0, `RESP_OKAY);
      rd(`OFF_MASK, 32'h0, `RESP_OKAY);
      rd(`OFF_PENDING, 32'h0, `RESP_OKAY);
      chk_irq(1'b0);
      for (int b = 3; b < 8; b++) begin
         wr(`OFF_ENABLE, 32'h1 << b, `RESP_OKAY);
         rd(`OFF_ENABLE, (b == 7) ? 32'h0 : 32'h1 << b, `RESP_OKAY);
      end
      wr(`OFF_ENABLE, 32'hFFFFFFFF, `RESP_OKAY);
      rd(`OFF_ENABLE, 32'h78, `RESP_OKAY);
      wr(`OFF_ENABLE, 32'h0, `RESP_OKAY);
      rd(`OFF_ENABLE, 32'h0, `RESP_OKAY);
      // A write whose lowest strobe is off leaves the register alone
      wstrb <= 4'hE;
      wr(`OFF_ENABLE, 32'h78, `RESP_OKAY);
      wstrb <= 4'hF;
      rd(`OFF_ENABLE, 32'h0, `RESP_OKAY);
      wr(8'h40, 32'hFF, `RESP_SLVERR);
      rd(8'h40, 32'h0, `RESP_SLVERR);
      // Block gating: loopback (bit 6) then data link (bit 3)
      for (int i = 0; i < 2; i++) begin
         eb = (i == 0) ? 32'h40 : 32'h08;
         wr(`OFF_ENABLE, 32'h0, `RESP_OKAY);
         wr(`OFF_SRC_EN, 32'hFF, `RESP_OKAY);
         fire(i * 3);
         chk_irq(1'b0);
         fire(4 + i);
         wr(`OFF_ENABLE, eb, `RESP_OKAY);
         chk_irq(1'b0);
         wr(`OFF_SRC_EN, 32'h0, `RESP_OKAY);
         fire(i * 3);
         chk_irq(1'b0);
         wr(`OFF_SRC_EN, 32'hFF, `RESP_OKAY);
         fire(i * 3);
         chk_irq(1'b1);
         rd(`OFF_PENDING, eb, `RESP_OKAY);
         wr(`OFF_ENABLE, 32'h0, `RESP_OKAY);
         chk_irq(1'b0);
         wr(`OFF_ENABLE, eb, `RESP_OKAY);
         chk_irq(1'b1);
         fire(4 + i);
         chk_irq(1'b0);
         rd(`OFF_PENDING, 32'h0, `RESP_OKAY);
      end
      // Source gating of clock loss (bit 5) and one second (bit 4) into sticky status
      for (int i = 0; i < 2; i++) begin
         eb = (i == 0) ? 32'h20 : 32'h10;
         wr(`OFF_MASK, 32'h30, `RESP_OKAY);
         wr(`OFF_ENABLE, 32'h0, `RESP_OKAY);
         rd(`OFF_STATUS, 32'h0, `RESP_OKAY, 1'b0);
         fire(1 + i);
         chk_irq(1'b0);
         rd(`OFF_STATUS, 32'h0, `RESP_OKAY);
         wr(`OFF_ENABLE, eb, `RESP_OKAY);
         fire(1 + i);
         chk_irq(1'b1);
         rd(`OFF_STATUS, eb, `RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk_irq(1'b0);
         wr(`OFF_MASK, 32'h0, `RESP_OKAY);
         fire(1 + i);
         chk_irq(1'b0);
         rd(`OFF_STATUS, eb, `RESP_OKAY);
      end
      report_and_stop();
   end
endmodule : tb_block_irq_enable
